// >>> hw/fpg_pkg.sv
package fpg_pkg;
    // ------------------------------------------------------------
    // Flash commands and status bits
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ_ARRAY = 8'h00_FF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h0070;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h0050;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h0040;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h0020;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'h00D0;
    localparam logic [7:0] STATUS_INIT = 8'h0080;
    localparam int READY_BIT = 7;
    localparam int ERASE_FAIL_BIT = 5;
    localparam int PROGRAM_FAIL_BIT = 4;
    localparam int SUPPLY_FAULT_BIT = 3;

    // ------------------------------------------------------------
    // Controller registers (word offsets in bytes)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_ADDR = 4'h4;
    localparam logic [3:0] OFS_DATA = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'hC;
    localparam logic [3:0] OFS_IRQ = 4'h0;
    localparam logic [2:0] OP_READ = 3'h1;
    localparam logic [2:0] OP_PROGRAM = 3'h2;
    localparam logic [2:0] OP_ERASE = 3'h3;
    localparam logic [2:0] OP_STATUS = 3'h4;
    localparam logic [2:0] OP_CLEAR = 3'h5;
    localparam logic [2:0] OP_SLEEP = 3'h6;
    localparam logic [2:0] OP_WAKE = 3'h7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int WAKEUP_ACCESS_NS = 600;
    localparam int WAKEUP_CYC = (WAKEUP_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_NS = 150;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = 2;
    localparam logic [4:0] WAKEUP_CNT = 5'(WAKEUP_CYC);
    localparam logic [4:0] ACCESS_CNT = 5'(ACCESS_CYC);
    localparam logic [4:0] STROBE_CNT = 5'(STROBE_CYC);
    localparam logic [4:0] POLL_GAP = 5'h0002;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_WR = 4'b0001,
        ST_WR_GAP = 4'b0011,
        ST_RD = 4'b0010,
        ST_POLL = 4'b0110,
        ST_WAKE = 4'b0111,
        ST_SLEEP = 4'b0101
    } fpg_state_t;

    typedef struct packed {
        logic [16:0] addr;
        logic [7:0] dq_out;
        logic dq_oe;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic power_control_n;
    } fpg_pins_t;
endpackage

// >>> hw/fpg_sync.sv
`timescale 1ns/1ps
module fpg_sync #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// >>> hw/fpg_host.sv
`timescale 1ns/1ps
module fpg_host (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output fpg_pkg::fpg_pins_t pins,
    input wire logic [7:0] dq_in
);
    // ------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------
    logic [7:0] dq_s;
    fpg_sync #(.W(8)) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .d(dq_in),
        .q(dq_s)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fpg_pkg::fpg_state_t st_r, st_nxt;
    fpg_pkg::fpg_pins_t pin_r, pin_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [2:0] op_r, op_nxt;
    logic [1:0] step_r, step_nxt;
    logic [16:0] addr_r, addr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] fstat_r, fstat_nxt;
    logic busy_r, busy_nxt;
    logic asleep_r, asleep_nxt;
    logic first_rd_r, first_rd_nxt;
    logic fault_lock_r, fault_lock_nxt;
    logic [1:0] ev_r, ev_nxt;
    logic [1:0] mask_r, mask_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic ack_r, ack_nxt;

    function automatic logic [7:0] cmd_of(input logic [2:0] op, input logic [1:0] step);
        unique case (op)
            fpg_pkg::OP_PROGRAM: cmd_of = fpg_pkg::CMD_PROG_SETUP;
            fpg_pkg::OP_ERASE: cmd_of = fpg_pkg::CMD_ERASE_SETUP;
            fpg_pkg::OP_CLEAR: cmd_of = fpg_pkg::CMD_CLEAR_STATUS;
            fpg_pkg::OP_STATUS: cmd_of = fpg_pkg::CMD_READ_STATUS;
            default: cmd_of = fpg_pkg::CMD_READ_ARRAY;
        endcase
        if (step == 2'h1 && op == fpg_pkg::OP_ERASE) cmd_of = fpg_pkg::CMD_ERASE_CONFIRM;
    endfunction

    wire logic acc = (avs_read | avs_write) & ~ack_r;
    wire logic go = avs_write & ~ack_r & (avs_address == fpg_pkg::OFS_CTRL) & ~busy_r;

    always_comb begin
        st_nxt = st_r;
        pin_nxt = pin_r;
        cnt_nxt = cnt_r;
        op_nxt = op_r;
        step_nxt = step_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        fstat_nxt = fstat_r;
        busy_nxt = busy_r;
        asleep_nxt = asleep_r;
        first_rd_nxt = first_rd_r;
        fault_lock_nxt = fault_lock_r;
        ev_nxt = ev_r;
        mask_nxt = mask_r;
        ack_nxt = acc;
        rd_nxt = rd_r;
        // Register bus side
        if (avs_write && !ack_r) begin
            unique case (avs_address)
                fpg_pkg::OFS_ADDR: addr_nxt = avs_writedata[16:0];
                fpg_pkg::OFS_DATA: wdata_nxt = avs_writedata[7:0];
                fpg_pkg::OFS_STAT: mask_nxt = avs_writedata[9:8];
                default: ;
            endcase
        end
        if (avs_read && !ack_r) begin
            unique case (avs_address)
                fpg_pkg::OFS_ADDR: rd_nxt = {15'h0000, addr_r};
                fpg_pkg::OFS_DATA: rd_nxt = {24'h00_0000, rdata_r};
                fpg_pkg::OFS_STAT: begin
                    rd_nxt = {20'h0_0000, 1'b0, fault_lock_r, mask_r, fstat_r};
                    rd_nxt[13:12] = ev_r;
                    ev_nxt = 2'h0;
                end
                fpg_pkg::OFS_CTRL: rd_nxt = {27'h000_0000, asleep_r, busy_r, op_r[1:0], 1'b0};
                default: rd_nxt = 32'h0000_0000;
            endcase
        end
        // Command launch
        if (go) begin
            op_nxt = avs_writedata[2:0];
            step_nxt = 2'h0;
            busy_nxt = 1'b1;
            if ((avs_writedata[2:0] == fpg_pkg::OP_PROGRAM ||
                 avs_writedata[2:0] == fpg_pkg::OP_ERASE) && fault_lock_r) begin
                busy_nxt = 1'b0;
                ev_nxt[1] = 1'b1;
            end else if (avs_writedata[2:0] == fpg_pkg::OP_SLEEP) begin
                pin_nxt.power_control_n = 1'b0;
                fstat_nxt = fpg_pkg::STATUS_INIT;
                fault_lock_nxt = 1'b0;
                asleep_nxt = 1'b1;
                st_nxt = fpg_pkg::ST_SLEEP;
            end else if (avs_writedata[2:0] == fpg_pkg::OP_WAKE) begin
                pin_nxt.power_control_n = 1'b1;
                first_rd_nxt = asleep_r;
                asleep_nxt = 1'b0;
                cnt_nxt = 5'h00;
                st_nxt = fpg_pkg::ST_WAKE;
            end else if (asleep_r) begin
                busy_nxt = 1'b0;
                ev_nxt[1] = 1'b1;
            end else begin
                st_nxt = fpg_pkg::ST_WR;
                cnt_nxt = 5'h00;
            end
        end
        unique case (st_r)
            fpg_pkg::ST_IDLE: ;
            fpg_pkg::ST_SLEEP: begin
                busy_nxt = 1'b0;
                st_nxt = fpg_pkg::ST_IDLE;
            end
            fpg_pkg::ST_WAKE: begin
                cnt_nxt = cnt_r + 5'h01;
                if (cnt_r == fpg_pkg::STROBE_CNT) begin
                    busy_nxt = 1'b0;
                    st_nxt = fpg_pkg::ST_IDLE;
                end
            end
            fpg_pkg::ST_WR: begin
                pin_nxt.ce_n = 1'b0;
                pin_nxt.we_n = 1'b0;
                pin_nxt.oe_n = 1'b1;
                pin_nxt.dq_oe = 1'b1;
                pin_nxt.addr = addr_r;
                // two-step sequence, data as second write
                pin_nxt.dq_out = (op_r == fpg_pkg::OP_PROGRAM && step_r == 2'h1) ?
                                 wdata_r : cmd_of(op_r, step_r);
                cnt_nxt = cnt_r + 5'h01;
                if (cnt_r == fpg_pkg::STROBE_CNT) begin
                    pin_nxt.we_n = 1'b1;
                    pin_nxt.ce_n = 1'b1;
                    cnt_nxt = 5'h00;
                    st_nxt = fpg_pkg::ST_WR_GAP;
                end
            end
            fpg_pkg::ST_WR_GAP: begin
                pin_nxt.dq_oe = 1'b0;
                cnt_nxt = 5'h00;
                if ((op_r == fpg_pkg::OP_PROGRAM || op_r == fpg_pkg::OP_ERASE) &&
                    step_r == 2'h0) begin
                    step_nxt = 2'h1;
                    st_nxt = fpg_pkg::ST_WR;
                end else if (op_r == fpg_pkg::OP_CLEAR) begin
                    fault_lock_nxt = 1'b0;
                    fstat_nxt = fpg_pkg::STATUS_INIT;
                    busy_nxt = 1'b0;
                    st_nxt = fpg_pkg::ST_IDLE;
                end else begin
                    st_nxt = (op_r == fpg_pkg::OP_READ || op_r == fpg_pkg::OP_STATUS) ?
                             fpg_pkg::ST_RD : fpg_pkg::ST_POLL;
                end
            end
            fpg_pkg::ST_RD, fpg_pkg::ST_POLL: begin
                pin_nxt.ce_n = 1'b0;
                pin_nxt.oe_n = 1'b0;
                cnt_nxt = cnt_r + 5'h01;
                // first access after wake-up waits longer
                if (cnt_r == (first_rd_r ? fpg_pkg::WAKEUP_CNT : fpg_pkg::ACCESS_CNT)) begin
                    pin_nxt.ce_n = 1'b1;
                    pin_nxt.oe_n = 1'b1;
                    first_rd_nxt = 1'b0;
                    cnt_nxt = 5'h00;
                    if (st_r == fpg_pkg::ST_RD) begin
                        rdata_nxt = dq_s;
                        if (op_r == fpg_pkg::OP_STATUS) fstat_nxt = dq_s;
                        busy_nxt = 1'b0;
                        st_nxt = fpg_pkg::ST_IDLE;
                    end else if (dq_s[fpg_pkg::READY_BIT]) begin
                        fstat_nxt = dq_s;
                        if (dq_s[fpg_pkg::SUPPLY_FAULT_BIT]) fault_lock_nxt = 1'b1;
                        ev_nxt[0] = 1'b1;
                        if (|dq_s[fpg_pkg::ERASE_FAIL_BIT:fpg_pkg::SUPPLY_FAULT_BIT])
                            ev_nxt[1] = 1'b1;
                        op_nxt = fpg_pkg::OP_READ;
                        step_nxt = 2'h1;
                        st_nxt = fpg_pkg::ST_WR;
                    end
                end
            end
            default: st_nxt = fpg_pkg::ST_IDLE;
        endcase
        // read array write leaves busy once issued
        if (st_r == fpg_pkg::ST_WR_GAP && op_r == fpg_pkg::OP_READ && step_r == 2'h1) begin
            busy_nxt = 1'b0;
            st_nxt = fpg_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r <= fpg_pkg::ST_IDLE;
            pin_r <= '{addr: 17'h0_0000, dq_out: 8'h00, dq_oe: 1'b0, ce_n: 1'b1,
                       we_n: 1'b1, oe_n: 1'b1, power_control_n: 1'b0};
            cnt_r <= 5'h00;
            op_r <= 3'h0;
            step_r <= 2'h0;
            addr_r <= 17'h0_0000;
            wdata_r <= 8'h00;
            rdata_r <= 8'h00;
            fstat_r <= fpg_pkg::STATUS_INIT;
            busy_r <= 1'b0;
            asleep_r <= 1'b1;
            first_rd_r <= 1'b0;
            fault_lock_r <= 1'b0;
            ev_r <= 2'h0;
            mask_r <= 2'h0;
            rd_r <= 32'h0000_0000;
            ack_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            pin_r <= pin_nxt;
            cnt_r <= cnt_nxt;
            op_r <= op_nxt;
            step_r <= step_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            fstat_r <= fstat_nxt;
            busy_r <= busy_nxt;
            asleep_r <= asleep_nxt;
            first_rd_r <= first_rd_nxt;
            fault_lock_r <= fault_lock_nxt;
            ev_r <= ev_nxt;
            mask_r <= mask_nxt;
            rd_r <= rd_nxt;
            ack_r <= ack_nxt;
        end
    end

    assign pins = pin_r;
    assign avs_readdata = rd_r;
    assign avs_waitrequest = ~ack_r;
    assign irq = |(ev_r & mask_r);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // strobe only with select
    strobe_select_a: assert property (@(posedge ref_clk) disable iff (reset)
        !pins.we_n |-> !pins.ce_n) else $error("write strobe without chip select");
    sleep_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
        !pins.power_control_n |-> pins.ce_n && pins.we_n) else $error("bus active in sleep");
    lock_refuse_a: assert property (@(posedge ref_clk) disable iff (reset)
        (fault_lock_r && st_r == fpg_pkg::ST_IDLE) |=> !(st_r == fpg_pkg::ST_WR &&
        (op_r == fpg_pkg::OP_PROGRAM || op_r == fpg_pkg::OP_ERASE) && step_r == 2'h0))
        else $error("program started while locked");
    sleep_status_a: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(pins.power_control_n) |-> fstat_r == fpg_pkg::STATUS_INIT)
        else $error("status not reset on sleep");
    wake_read_a: assert property (@(posedge ref_clk) disable iff (reset)
        (st_r == fpg_pkg::ST_RD && first_rd_r && $fell(pins.oe_n)) |->
        !pins.oe_n [*8]) else $error("wake-up read too short");
endmodule

// >>> testbench/fpg_flash_model.sv
`timescale 1ns/1ps
module fpg_flash_model #(
    parameter int WAKE_CYC = 8,
    parameter int BUSY_CYC = 20
) (
    input wire logic ref_clk,
    input wire fpg_pkg::fpg_pins_t pins,
    input wire logic vpp_low,
    input wire logic fail_inj,
    output logic [7:0] dq_in
);
    // ------------------------------------------------------------
    // Behavioural byte-wide flash
    // ------------------------------------------------------------
    logic [7:0] mem [16];
    logic [7:0] cmd_r, stat_r, pend_r, d_r, last_r;
    logic [16:0] a_r;
    logic act, act_q, rd_en;
    int busy, wake;
    assign act = !pins.we_n && !pins.ce_n;
    assign rd_en = !pins.ce_n && !pins.oe_n && pins.power_control_n && wake >= WAKE_CYC;
    // idle or waking bus shows inverted data
    assign dq_in = !rd_en ? ~last_r : (cmd_r != fpg_pkg::CMD_READ_ARRAY) ?
        {busy == 0, stat_r[6:0]} : mem[pins.addr[3:0]];
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        cmd_r = fpg_pkg::CMD_READ_ARRAY;
        pend_r = fpg_pkg::CMD_READ_ARRAY;
        stat_r = fpg_pkg::STATUS_INIT;
        last_r = 8'h00;
        act_q = 1'b0;
        busy = 0;
        wake = 0;
    end
    always @(posedge ref_clk) begin
        act_q <= act;
        if (act) begin
            d_r <= pins.dq_out;
            a_r <= pins.addr;
        end
        if (rd_en) last_r <= dq_in;
        if (wake < WAKE_CYC) wake <= wake + 1;
        if (busy > 0) busy <= busy - 1;
        if (!pins.power_control_n) begin
            if (busy > 0) mem[a_r[3:0]] <= mem[a_r[3:0]] ^ 8'h0F;
            busy <= 0;
            wake <= 0;
            stat_r <= fpg_pkg::STATUS_INIT;
            cmd_r <= fpg_pkg::CMD_READ_ARRAY;
            pend_r <= fpg_pkg::CMD_READ_ARRAY;
        // write taken once the strobes rise again
        end else if (act_q && !act) begin
            pend_r <= fpg_pkg::CMD_READ_ARRAY;
            cmd_r <= fpg_pkg::CMD_READ_STATUS;
            // data only after a setup command
            if (pend_r == fpg_pkg::CMD_PROG_SETUP) begin
                if (vpp_low || stat_r[3]) stat_r <= stat_r | 8'h18;
                else if (fail_inj) stat_r <= stat_r | 8'h10;
                else begin
                    mem[a_r[3:0]] <= d_r;
                    busy <= BUSY_CYC;
                end
            end else if (pend_r == fpg_pkg::CMD_ERASE_SETUP) begin
                if (d_r != fpg_pkg::CMD_ERASE_CONFIRM) stat_r <= stat_r | 8'h30;
                else if (vpp_low || stat_r[3]) stat_r <= stat_r | 8'h28;
                else if (fail_inj) stat_r <= stat_r | 8'h20;
                else begin
                    foreach (mem[i]) mem[i] <= 8'hFF;
                    busy <= 2 * BUSY_CYC;
                end
            end else begin
                cmd_r <= d_r;
                if (d_r == fpg_pkg::CMD_PROG_SETUP || d_r == fpg_pkg::CMD_ERASE_SETUP) pend_r <= d_r;
                if (d_r == fpg_pkg::CMD_CLEAR_STATUS) stat_r <= fpg_pkg::STATUS_INIT;
            end
        end
    end
endmodule

// >>> testbench/fpg_host_tb.sv
`timescale 1ns/1ps
module fpg_host_tb;
    logic ref_clk, reset, avs_read, avs_write, irq, avs_waitrequest, vpp_low, fail_inj;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [7:0] dq_in;
    fpg_pkg::fpg_pins_t pins;
    int errors, samples_checked;

    fpg_host i_fpg_host (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .pins(pins), .dq_in(dq_in));
    fpg_flash_model i_fpg_flash_model (.ref_clk(ref_clk), .pins(pins), .vpp_low(vpp_low),
        .fail_inj(fail_inj), .dq_in(dq_in));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic close_out;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic hang;
        errors++;
        $display("FAIL %0t wait bound used up", $time);
        close_out;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // ------------------------------------------------------------
    // Avalon transfers and controller operations
    // ------------------------------------------------------------
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
        if (n >= 50) hang;
    endtask
    task automatic op(input logic [2:0] code);
        int n;
        av(1'b1, fpg_pkg::OFS_CTRL, {29'h0000_0000, code});
        n = 0;
        do begin
            av(1'b0, fpg_pkg::OFS_CTRL, 32'h0000_0000);
            n++;
        end while (rd[3] !== 1'b0 && n < 400);
        if (n >= 400) hang;
    endtask
    task automatic stat(input logic [31:0] m, input logic [31:0] e);
        av(1'b0, fpg_pkg::OFS_STAT, 32'h0000_0000);
        chk(rd & m, e);
    endtask
    task automatic run(input logic [16:0] a, input logic [7:0] d, input logic [2:0] code);
        av(1'b1, fpg_pkg::OFS_ADDR, {15'h0000, a});
        av(1'b1, fpg_pkg::OFS_DATA, {24'h00_0000, d});
        op(code);
    endtask
    task automatic rd_byte(input logic [16:0] a, input logic [7:0] e);
        run(a, 8'h00, fpg_pkg::OP_READ);
        av(1'b0, fpg_pkg::OFS_DATA, 32'h0000_0000);
        chk(rd & 32'h0000_00FF, {24'h00_0000, e});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_asleep;
        chk(32'(pins.power_control_n), 32'h0000_0000);
        chk(32'(pins.we_n), 32'h0000_0001);
        av(1'b0, 4'h2, 32'h0000_0000);
        run(17'h0_0000, 8'h12, fpg_pkg::OP_PROGRAM);
        stat(32'h0000_3000, 32'h0000_2000);
    endtask
    task automatic t_wake;
        op(fpg_pkg::OP_WAKE);
        chk(rd & 32'h0000_0018, 32'h0000_0000);
        chk(32'(pins.power_control_n), 32'h0000_0001);
        rd_byte(17'h0_0000, 8'hFF);
    endtask
    task automatic t_program;
        run(17'h1_FFFF, 8'h5A, fpg_pkg::OP_PROGRAM);
        stat(32'h0000_30FF, 32'h0000_1080);
        run(17'h0_0000, 8'hA5, fpg_pkg::OP_PROGRAM);
        stat(32'h0000_30FF, 32'h0000_1080);
        rd_byte(17'h1_FFFF, 8'h5A);
        rd_byte(17'h0_0000, 8'hA5);
        run(17'h0_0000, 8'h00, fpg_pkg::OP_ERASE);
        stat(32'h0000_30FF, 32'h0000_1080);
        rd_byte(17'h1_FFFF, 8'hFF);
    endtask
    task automatic t_fail;
        fail_inj <= 1'b1;
        run(17'h0_0003, 8'h00, fpg_pkg::OP_PROGRAM);
        stat(32'h0000_00FF, 32'h0000_0090);
        run(17'h0_0003, 8'h00, fpg_pkg::OP_ERASE);
        stat(32'h0000_00FF, 32'h0000_00B0);
        fail_inj <= 1'b0;
        op(fpg_pkg::OP_CLEAR);
        rd_byte(17'h0_0003, 8'hFF);
    endtask
    task automatic t_supply;
        vpp_low <= 1'b1;
        run(17'h0_0004, 8'h33, fpg_pkg::OP_PROGRAM);
        stat(32'h0000_04FF, 32'h0000_0498);
        vpp_low <= 1'b0;
        run(17'h0_0004, 8'h33, fpg_pkg::OP_PROGRAM);
        stat(32'h0000_2400, 32'h0000_2400);
        op(fpg_pkg::OP_CLEAR);
        run(17'h0_0004, 8'h33, fpg_pkg::OP_PROGRAM);
        stat(32'h0000_3408, 32'h0000_1000);
        rd_byte(17'h0_0004, 8'h33);
    endtask
    task automatic t_irq;
        av(1'b1, fpg_pkg::OFS_STAT, 32'h0000_0100);
        stat(32'h0000_0300, 32'h0000_0100);
        run(17'h0_0005, 8'h77, fpg_pkg::OP_PROGRAM);
        chk(32'(irq), 32'h0000_0001);
        stat(32'h0000_1000, 32'h0000_1000);
        repeat (2) @(posedge ref_clk);
        chk(32'(irq), 32'h0000_0000);
        av(1'b1, fpg_pkg::OFS_STAT, 32'h0000_0000);
        run(17'h0_0006, 8'h66, fpg_pkg::OP_PROGRAM);
        chk(32'(irq), 32'h0000_0000);
    endtask
    task automatic t_sleep;
        vpp_low <= 1'b1;
        run(17'h0_0007, 8'h11, fpg_pkg::OP_PROGRAM);
        vpp_low <= 1'b0;
        op(fpg_pkg::OP_SLEEP);
        chk(32'(pins.power_control_n), 32'h0000_0000);
        op(fpg_pkg::OP_WAKE);
        op(fpg_pkg::OP_STATUS);
        stat(32'h0000_04FF, 32'h0000_0080);
    endtask

    initial begin
        reset = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0000_0000;
        vpp_low = 1'b0;
        fail_inj = 1'b0;
        errors = 0;
        samples_checked = 0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        t_asleep;
        t_wake;
        t_program;
        t_fail;
        t_supply;
        t_irq;
        t_sleep;
        close_out;
    end
endmodule
